//--- logic/adcf_consts.svh
// Purpose: Shared constants of the converter front-end control block.
// Assumes: Included by bare name after adcf_pkg is compiled.
// Notes:   Offsets, field positions, reset values, command codes and timing counts.
`ifndef ADCF_CONSTS_SVH
`define ADCF_CONSTS_SVH

// ----------------------------------------------------------------
// Commands
// ----------------------------------------------------------------
`define ADCF_CMD_RESET 8'h01
`define ADCF_CMD_START 8'h02
`define ADCF_CMD_PDOWN 8'h03
`define ADCF_CMD_RDATA 8'h04
`define ADCF_CMD_RREG_HI 6'h04
`define ADCF_CMD_WREG_HI 6'h08

// ----------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------
`define ADCF_NUM_REGS 4
`define ADCF_REG_RST 8'h00
`define ADCF_REG_FE 2'h0
`define ADCF_REG_CONV 2'h1
`define ADCF_REG_STAT 2'h2
`define ADCF_REG_EXC 2'h3
`define ADCF_SEL_MSB 7
`define ADCF_SEL_LSB 4
`define ADCF_GAIN_MSB 3
`define ADCF_GAIN_LSB 1
`define ADCF_BYP_BIT 0
`define ADCF_RATE_MSB 7
`define ADCF_RATE_LSB 5
`define ADCF_TURBO_BIT 4
`define ADCF_CONT_BIT 3
`define ADCF_RDY_BIT 7
`define ADCF_EXC1_MSB 7
`define ADCF_EXC1_LSB 5
`define ADCF_EXC2_MSB 4
`define ADCF_EXC2_LSB 2

// ----------------------------------------------------------------
// Input selection and gain
// ----------------------------------------------------------------
`define ADCF_SEL_SE_HI 2'h2
`define ADCF_SEL_REFMON 4'hC
`define ADCF_SEL_SUPMON 4'hD
`define ADCF_PAIR_TABLE 32'hEB764321
`define ADCF_SC_EXP_MAX 3'h2
`define ADCF_EXC_LAST 3'h6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCF_RESULT_W 16
`define ADCF_MCLK_MHZ 125
`define ADCF_START_DELAY_NS 27832
`define ADCF_START_DELAY_CYC ((`ADCF_START_DELAY_NS * `ADCF_MCLK_MHZ + 999) / 1000)

`endif

//--- logic/adcf_link.sv
// Purpose: Serial command receiver and read-back shifter on the link clock.
// Assumes: Data is sampled and driven on the falling edge of link_scl.
// Notes:   Words cross to the core by toggle handshakes with stable holding registers.
`include "adcf_consts.svh"

module adcf_link (
  // Clock and reset
  input wire logic link_scl,
  input wire logic rst,
  // Serial pins
  input wire logic link_frame,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Command handover to the core
  output logic [15:0] cmd_word,
  output logic cmd_req,
  // Snapshot handover from the core
  input wire logic [47:0] pub_word,
  input wire logic pub_req,
  output logic pub_ack
);

  logic frame_clr;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] shift, next_shift;
  logic data_phase, next_data_phase;
  logic [7:0] cmd_byte, next_cmd_byte;
  logic [15:0] tx, next_tx;
  logic [4:0] tx_left, next_tx_left;
  logic next_sda_out, next_sda_oe;
  logic [15:0] next_cmd_word;
  logic next_cmd_req;
  logic req_s1, req_s2, next_req_s1, next_req_s2, next_pub_ack;
  logic [47:0] snap, next_snap, snap_now;
  logic [7:0] rx_byte;
  logic cmd_done;

  // The bit machine restarts whenever the frame is dropped.
  assign frame_clr = rst | ~link_frame;

  always_comb
  begin
    rx_byte = {shift, sda_in};
    cmd_done = 1'b0;
    // A word offered on this very edge is shifted out at once, so a read never lags.
    snap_now = ((req_s2 != pub_ack) && (tx_left == 5'h00)) ? pub_word : snap;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_data_phase = data_phase;
    next_cmd_byte = cmd_byte;
    next_tx = tx;
    next_tx_left = tx_left;
    next_sda_out = sda_out;
    next_sda_oe = 1'b0;
    next_cmd_word = cmd_word;
    next_req_s1 = pub_req;
    next_req_s2 = req_s1;
    next_pub_ack = pub_ack;
    next_snap = snap;
    if (tx_left != 5'h00)
    begin
      next_sda_out = tx[15];
      next_sda_oe = 1'b1;
      next_tx = {tx[14:0], 1'b0};
      next_tx_left = tx_left - 5'h01;
    end
    else
    begin
      next_bit_cnt = bit_cnt + 3'h1;
      next_shift = rx_byte[6:0];
      if (bit_cnt == 3'h7)
      begin
        if (data_phase)
        begin
          next_data_phase = 1'b0;
          next_cmd_word = {cmd_byte, rx_byte};
          cmd_done = 1'b1;
        end
        else if (rx_byte[7:2] == `ADCF_CMD_WREG_HI)
        begin
          next_data_phase = 1'b1;
          next_cmd_byte = rx_byte;
        end
        else
        begin
          // Eighth falling edge of the command byte: the command is latched here.
          next_cmd_word = {rx_byte, 8'h00};
          cmd_done = 1'b1;
          if (rx_byte == `ADCF_CMD_RDATA)
          begin
            next_tx = snap_now[47:32];
            next_tx_left = 5'h10;
          end
          else if (rx_byte[7:2] == `ADCF_CMD_RREG_HI)
          begin
            next_tx = {snap_now[{rx_byte[1:0], 3'h0} +: 8], 8'h00};
            next_tx_left = 5'h08;
          end
        end
      end
    end
    next_cmd_req = cmd_done ? ~cmd_req : cmd_req;
    // The snapshot is frozen while a word is shifted out, so no read sees a mix.
    if ((req_s2 != pub_ack) && (tx_left == 5'h00))
    begin
      next_snap = pub_word;
      next_pub_ack = req_s2;
    end
  end

  always_ff @(negedge link_scl or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      data_phase <= 1'b0;
      cmd_byte <= 8'h00;
      tx <= 16'h0000;
      tx_left <= 5'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      data_phase <= next_data_phase;
      cmd_byte <= next_cmd_byte;
      tx <= next_tx;
      tx_left <= next_tx_left;
      sda_out <= next_sda_out;
      sda_oe <= next_sda_oe;
    end
  end

  always_ff @(negedge link_scl or posedge rst)
  begin
    if (rst)
    begin
      cmd_word <= 16'h0000;
      cmd_req <= 1'b0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      pub_ack <= 1'b0;
      snap <= 48'h000000000000;
    end
    else
    begin
      cmd_word <= next_cmd_word;
      cmd_req <= next_cmd_req;
      req_s1 <= next_req_s1;
      req_s2 <= next_req_s2;
      pub_ack <= next_pub_ack;
      snap <= next_snap;
    end
  end

  property p_cmd_latch;
    @(negedge link_scl) disable iff (frame_clr)
    cmd_done |=> (cmd_req != $past(cmd_req))
      && (cmd_word[7:0] == ($past(data_phase) ? $past(rx_byte) : 8'h00))
      && (cmd_word[15:8] == ($past(data_phase) ? $past(cmd_byte) : $past(rx_byte)));
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("command not latched on eighth edge");

  property p_snap_frozen;
    @(negedge link_scl) disable iff (frame_clr)
    (tx_left != 5'h00) |=> $stable(snap);
  endproperty
  a_snap_frozen: assert property (p_snap_frozen) else $error("snapshot changed during read");

endmodule

//--- logic/adcf_pkg.sv
// Purpose: Types of the converter front-end control block.
// Assumes: Nothing.
// Notes:   Constants live in adcf_consts.svh.
package adcf_pkg;

  typedef enum logic [1:0] {st_idle, st_wait, st_conv} adcf_state_t;

  typedef struct packed {
    logic [1:0] pos_pin;
    logic [1:0] neg_pin;
    logic neg_to_analog_neg_supply;
    logic ref_mon;
    logic supply_mon;
    logic shorted;
  } adcf_route_t;

  typedef struct packed {
    logic amp_enable;
    logic [2:0] amp_exp;
    logic [2:0] sc_exp;
  } adcf_gain_t;

  typedef struct packed {
    logic [5:0] dest;
  } adcf_exc_t;

endpackage

//--- logic/adcf_top.sv
// Purpose: Conversion sequencing and front-end decode of a delta-sigma converter.
// Assumes: The filter returns each result on filt_valid in the mclk domain.
// Notes:   The serial link runs on link_scl; commands and snapshots cross by handshake.
//
// Contract
// - Single-shot performs one conversion, stores it, then returns to low-power idle.
// - Continuous mode starts the next conversion right after each one finishes.
// - A result read always returns the whole latest completed word, never partial.
// - Four configuration registers; six serial commands drive operation.
// - Four-bit input select picks single-ended, differential or mixed pairings.
// - Any single-ended selection ties the negative converter input to the negative supply.
// - Monitor selections feed supply difference or reference difference, each divided by four.
// - Each excitation current source routes independently to any input or reference pin.
// - Three-bit gain select sets overall gain from 1 to 128.
// - Gains above four use switched-capacitor gain four; amplifier supplies 2 to 32.
// - Gains 1, 2, 4 come from switched-capacitor stage alone, amplifier at unity.
// - Single-ended selections force amplifier bypass and clamp gain above four to four.
// - Amplifier bypass bit is honoured only at gains 1, 2 and 4.
// - Commands latch on eighth falling serial clock edge; conversion timing starts there.
`include "adcf_consts.svh"

module adcf_top (
  // Clocks and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic link_scl,
  // Serial link
  input wire logic link_frame,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Digital filter
  input wire logic filt_valid,
  input wire logic [`ADCF_RESULT_W-1:0] filt_data,
  // Converter control
  output logic conv_start,
  output logic conv_active,
  output logic [2:0] data_rate,
  output logic turbo,
  // Front end
  output adcf_pkg::adcf_route_t mux_route,
  output adcf_pkg::adcf_gain_t gain_cfg,
  output adcf_pkg::adcf_exc_t exc1,
  output adcf_pkg::adcf_exc_t exc2,
  // Status
  output logic data_ready_n,
  output logic [`ADCF_RESULT_W-1:0] result
);

  localparam logic [31:0] PAIR_TBL = `ADCF_PAIR_TABLE;
  localparam logic [11:0] START_CYC = 12'(`ADCF_START_DELAY_CYC);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic adcf_pkg::adcf_route_t route_of(input logic [3:0] sel);
    adcf_pkg::adcf_route_t r;
    r = '0;
    if (sel[3:2] == `ADCF_SEL_SE_HI)
    begin
      r.pos_pin = sel[1:0];
      r.neg_to_analog_neg_supply = 1'b1;
    end
    else if (sel == `ADCF_SEL_REFMON)
      r.ref_mon = 1'b1;
    else if (sel == `ADCF_SEL_SUPMON)
      r.supply_mon = 1'b1;
    else if (sel[3])
      r.shorted = 1'b1;
    else
      {r.pos_pin, r.neg_pin} = PAIR_TBL[{sel[2:0], 2'h0} +: 4];
    return r;
  endfunction

  function automatic adcf_pkg::adcf_gain_t gain_split(input logic se, input logic [2:0] code,
                                                     input logic byp);
    adcf_pkg::adcf_gain_t g;
    logic [2:0] eff;
    eff = (se && (code > `ADCF_SC_EXP_MAX)) ? `ADCF_SC_EXP_MAX : code;
    // Overall gain is two to the power of eff.
    g.sc_exp = (eff > `ADCF_SC_EXP_MAX) ? `ADCF_SC_EXP_MAX : eff;
    g.amp_exp = (eff > `ADCF_SC_EXP_MAX) ? eff - `ADCF_SC_EXP_MAX : 3'h0;
    g.amp_enable = !(se || (byp && (eff <= `ADCF_SC_EXP_MAX)));
    return g;
  endfunction

  function automatic adcf_pkg::adcf_exc_t exc_of(input logic [2:0] code);
    adcf_pkg::adcf_exc_t e;
    e.dest = 6'h00;
    if ((code != 3'h0) && (code <= `ADCF_EXC_LAST))
      e.dest = 6'h01 << (code - 3'h1);
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Link and crossings
  // ----------------------------------------------------------------
  logic [15:0] cmd_word;
  logic cmd_req, pub_ack;
  logic [47:0] pub_word, next_pub_word;
  logic pub_req, next_pub_req;
  logic cq1, cq2, cq3, aq1, aq2;

  adcf_link u_link (
    .link_scl(link_scl),
    .rst(rst),
    .link_frame(link_frame),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .cmd_word(cmd_word),
    .cmd_req(cmd_req),
    .pub_word(pub_word),
    .pub_req(pub_req),
    .pub_ack(pub_ack)
  );

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cq1 <= 1'b0;
      cq2 <= 1'b0;
      cq3 <= 1'b0;
      aq1 <= 1'b0;
      aq2 <= 1'b0;
    end
    else
    begin
      cq1 <= cmd_req;
      cq2 <= cq1;
      cq3 <= cq2;
      aq1 <= pub_ack;
      aq2 <= aq1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and sequencer
  // ----------------------------------------------------------------
  logic [7:0] cfg [`ADCF_NUM_REGS];
  logic [7:0] next_cfg [`ADCF_NUM_REGS];
  adcf_pkg::adcf_state_t state, next_state;
  logic [11:0] delay, next_delay;
  logic next_conv_start, next_conv_active, next_data_ready_n;
  logic [`ADCF_RESULT_W-1:0] next_result;
  logic cmd_ev, store, clear_rdy, cont;
  logic [7:0] cmd, wdata, stat_rd;

  always_comb
  begin
    cmd_ev = cq2 ^ cq3;
    cmd = cmd_word[15:8];
    wdata = cmd_word[7:0];
    cont = cfg[`ADCF_REG_CONV][`ADCF_CONT_BIT];
    store = 1'b0;
    clear_rdy = 1'b0;
    next_cfg = cfg;
    next_state = state;
    next_delay = delay;
    next_conv_start = 1'b0;
    next_result = result;
    case (state)
      adcf_pkg::st_idle:
        next_state = adcf_pkg::st_idle;
      adcf_pkg::st_wait:
        if (delay == 12'h000)
        begin
          next_state = adcf_pkg::st_conv;
          next_conv_start = 1'b1;
        end
        else
          next_delay = delay - 12'h001;
      adcf_pkg::st_conv:
        if (filt_valid)
        begin
          store = 1'b1;
          // The whole word is taken on one edge.
          next_result = filt_data;
          if (cont)
            next_conv_start = 1'b1;
          else
            next_state = adcf_pkg::st_idle;
        end
      default:
        next_state = adcf_pkg::st_idle;
    endcase
    if (cmd_ev)
    begin
      if (cmd == `ADCF_CMD_RESET)
      begin
        for (int i = 0; i < `ADCF_NUM_REGS; i++)
          next_cfg[i] = `ADCF_REG_RST;
        next_state = adcf_pkg::st_idle;
        next_conv_start = 1'b0;
      end
      else if (cmd == `ADCF_CMD_START)
      begin
        // A start during a conversion restarts the sequence from the latch.
        next_state = adcf_pkg::st_wait;
        next_delay = START_CYC;
        next_conv_start = 1'b0;
        clear_rdy = 1'b1;
      end
      else if (cmd == `ADCF_CMD_PDOWN)
      begin
        next_state = adcf_pkg::st_idle;
        next_conv_start = 1'b0;
      end
      else if (cmd == `ADCF_CMD_RDATA)
        clear_rdy = 1'b1;
      else if (cmd[7:2] == `ADCF_CMD_WREG_HI)
        next_cfg[cmd[1:0]] = wdata;
    end
    next_conv_active = (next_state != adcf_pkg::st_idle);
    next_data_ready_n = data_ready_n;
    if (clear_rdy)
      next_data_ready_n = 1'b1;
    if (store)
      next_data_ready_n = 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `ADCF_NUM_REGS; i++)
        cfg[i] <= `ADCF_REG_RST;
      state <= adcf_pkg::st_idle;
      delay <= 12'h000;
      conv_start <= 1'b0;
      conv_active <= 1'b0;
      data_ready_n <= 1'b1;
      result <= 16'h0000;
    end
    else
    begin
      cfg <= next_cfg;
      state <= next_state;
      delay <= next_delay;
      conv_start <= next_conv_start;
      conv_active <= next_conv_active;
      data_ready_n <= next_data_ready_n;
      result <= next_result;
    end
  end

  // ----------------------------------------------------------------
  // Front-end decode and snapshot publishing
  // ----------------------------------------------------------------
  logic [3:0] sel;
  logic [2:0] gain_code;
  logic sel_se, byp;
  adcf_pkg::adcf_route_t next_mux_route;
  adcf_pkg::adcf_gain_t next_gain_cfg;
  adcf_pkg::adcf_exc_t next_exc1, next_exc2;
  logic [2:0] next_data_rate;
  logic next_turbo;

  always_comb
  begin
    sel = cfg[`ADCF_REG_FE][`ADCF_SEL_MSB:`ADCF_SEL_LSB];
    gain_code = cfg[`ADCF_REG_FE][`ADCF_GAIN_MSB:`ADCF_GAIN_LSB];
    byp = cfg[`ADCF_REG_FE][`ADCF_BYP_BIT];
    sel_se = (sel[3:2] == `ADCF_SEL_SE_HI);
    next_mux_route = route_of(sel);
    next_gain_cfg = gain_split(sel_se, gain_code, byp);
    next_exc1 = exc_of(cfg[`ADCF_REG_EXC][`ADCF_EXC1_MSB:`ADCF_EXC1_LSB]);
    next_exc2 = exc_of(cfg[`ADCF_REG_EXC][`ADCF_EXC2_MSB:`ADCF_EXC2_LSB]);
    next_data_rate = cfg[`ADCF_REG_CONV][`ADCF_RATE_MSB:`ADCF_RATE_LSB];
    next_turbo = cfg[`ADCF_REG_CONV][`ADCF_TURBO_BIT];
    stat_rd = cfg[`ADCF_REG_STAT];
    stat_rd[`ADCF_RDY_BIT] = ~data_ready_n;
    next_pub_word = pub_word;
    next_pub_req = pub_req;
    // A new snapshot is offered only once the link has taken the previous one.
    if (aq2 == pub_req)
    begin
      next_pub_word = {result, cfg[`ADCF_REG_EXC], stat_rd, cfg[`ADCF_REG_CONV],
                       cfg[`ADCF_REG_FE]};
      next_pub_req = ~pub_req;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mux_route <= '0;
      gain_cfg <= '0;
      exc1 <= '0;
      exc2 <= '0;
      data_rate <= 3'h0;
      turbo <= 1'b0;
      pub_word <= 48'h000000000000;
      pub_req <= 1'b0;
    end
    else
    begin
      mux_route <= next_mux_route;
      gain_cfg <= next_gain_cfg;
      exc1 <= next_exc1;
      exc2 <= next_exc2;
      data_rate <= next_data_rate;
      turbo <= next_turbo;
      pub_word <= next_pub_word;
      pub_req <= next_pub_req;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_single_idle;
    @(posedge mclk) disable iff (rst)
    (state == adcf_pkg::st_conv) && filt_valid && !cont && !cmd_ev
      |=> (state == adcf_pkg::st_idle) && !conv_start ##1 !conv_active;
  endproperty
  a_single_idle: assert property (p_single_idle) else $error("single shot did not idle");

  property p_cont_restart;
    @(posedge mclk) disable iff (rst)
    (state == adcf_pkg::st_conv) && filt_valid && cont && !cmd_ev
      |=> conv_start && (state == adcf_pkg::st_conv);
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("no restart");

  property p_result_whole;
    @(posedge mclk) disable iff (rst)
    (state == adcf_pkg::st_conv) && filt_valid |=> (result == $past(filt_data));
  endproperty
  a_result_whole: assert property (p_result_whole) else $error("result not stored");

  property p_result_stable;
    @(posedge mclk) disable iff (rst)
    !((state == adcf_pkg::st_conv) && filt_valid) |=> $stable(result);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result changed");

  property p_data_ready_n;
    @(posedge mclk) disable iff (rst)
    (state == adcf_pkg::st_conv) && filt_valid |=> !data_ready_n;
  endproperty
  a_data_ready_n: assert property (p_data_ready_n) else $error("data ready not asserted");

  property p_wreg;
    @(posedge mclk) disable iff (rst)
    cmd_ev && (cmd[7:2] == `ADCF_CMD_WREG_HI) |=> (cfg[$past(cmd[1:0])] == $past(wdata));
  endproperty
  a_wreg: assert property (p_wreg) else $error("register write lost");

  property p_start_timing;
    @(posedge mclk) disable iff (rst)
    cmd_ev && (cmd == `ADCF_CMD_START)
      |=> (state == adcf_pkg::st_wait) && (delay == START_CYC) && !conv_start;
  endproperty
  a_start_timing: assert property (p_start_timing) else $error("start not timed");

  property p_se_route;
    @(posedge mclk) disable iff (rst)
    sel_se |=> mux_route.neg_to_analog_neg_supply && (mux_route.pos_pin == $past(sel[1:0]));
  endproperty
  a_se_route: assert property (p_se_route) else $error("single-ended switch open");

  property p_se_clamp;
    @(posedge mclk) disable iff (rst)
    sel_se ##1 sel_se |=> !gain_cfg.amp_enable && (gain_cfg.amp_exp == 3'h0)
      && (gain_cfg.sc_exp <= `ADCF_SC_EXP_MAX);
  endproperty
  a_se_clamp: assert property (p_se_clamp) else $error("single-ended gain not clamped");

  property p_gain_split;
    @(posedge mclk) disable iff (rst)
    !sel_se && (gain_code > `ADCF_SC_EXP_MAX)
      |=> gain_cfg.amp_enable && (gain_cfg.sc_exp == `ADCF_SC_EXP_MAX)
      && (gain_cfg.amp_exp + gain_cfg.sc_exp == $past(gain_code));
  endproperty
  a_gain_split: assert property (p_gain_split) else $error("gain split wrong");

  property p_bypass;
    @(posedge mclk) disable iff (rst)
    !sel_se && (gain_code <= `ADCF_SC_EXP_MAX)
      |=> (gain_cfg.amp_enable == !$past(byp)) && (gain_cfg.amp_exp == 3'h0)
      && (gain_cfg.sc_exp == $past(gain_code));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass handling wrong");

endmodule

//--- tb/adcf_host.sv
// Purpose: Host model that drives the serial link of the converter block.
// Assumes: The device samples data on the falling link clock edge.
// Notes:   The link clock runs only inside frames; the data line idles high.
module adcf_host (
  // Link outputs
  output logic link_scl,
  output logic link_frame,
  output logic sda_in,
  // Device drive
  input wire logic sda_out,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic h_sda = 1'b1;
  // The data line is pulled up, so a released line reads high.
  assign sda_in = sda_oe ? sda_out : h_sda;
  initial
  begin
    link_scl = 1'b0;
    link_frame = 1'b0;
  end
  // ----------------------------------------------------------------
  // One frame: nt bits out, nr bits back, then eight idle clock pulses.
  // ----------------------------------------------------------------
  task automatic frame(input logic [15:0] tx, input int nt, input int nr,
                       output logic [15:0] q);
    q = '0;
    link_frame = 1'b1;
    #6;
    for (int i = nt - 1; i >= 0; i--)
    begin
      h_sda = tx[i];
      #3 link_scl = 1'b1;
      #6 link_scl = 1'b0;
      #3;
    end
    h_sda = 1'b1;
    for (int i = nr - 1; i >= 0; i--)
    begin
      #3 link_scl = 1'b1;
      #6 link_scl = 1'b0;
      #2 q[i] = sda_in;
      #1;
    end
    repeat (8)
    begin
      #6 link_scl = 1'b1;
      #6 link_scl = 1'b0;
    end
    link_frame = 1'b0;
    #12;
  endtask
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the converter front-end control block.
// Assumes: The host model supplies the serial link.
// Notes:   Decode rows first, then the conversion sequences.
`include "adcf_consts.svh"
`define CHK(a, b) \
  begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic link_scl, link_frame, sda_in, sda_out, sda_oe;
  logic filt_valid = 1'b0;
  logic [`ADCF_RESULT_W-1:0] filt_data = '0;
  logic conv_start, conv_active, turbo, data_ready_n;
  logic [2:0] data_rate;
  logic [`ADCF_RESULT_W-1:0] result, rd;
  adcf_pkg::adcf_route_t mux_route;
  adcf_pkg::adcf_gain_t gain_cfg;
  adcf_pkg::adcf_exc_t exc1, exc2;
  int fail_count = 0;
  int check_count = 0;
  int n;
  // Rows: config byte, route, route mask, gain.
  localparam logic [30:0] ROWS [8] = '{{8'h0E, 8'h10, 8'hFF, 7'h6A}, {8'h13, 8'h20, 8'hFF, 7'h01},
    {8'h79, 8'hE0, 8'hFF, 7'h52}, {8'h9C, 8'h48, 8'hCF, 7'h02}, {8'h84, 8'h08, 8'hCF, 7'h02},
    {8'hC0, 8'h04, 8'h0F, 7'h40}, {8'hD6, 8'h02, 8'h0F, 7'h4A}, {8'hE1, 8'h01, 8'h0F, 7'h00}};
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  adcf_host host (.link_scl, .link_frame, .sda_in, .sda_out, .sda_oe);
  adcf_top uut (.mclk, .rst, .link_scl, .link_frame, .sda_in, .sda_out, .sda_oe,
    .filt_valid, .filt_data, .conv_start, .conv_active, .data_rate, .turbo,
    .mux_route, .gain_cfg, .exc1, .exc2, .data_ready_n, .result);
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_start(output int c);
    c = 0;
    while (conv_start !== 1'b1 && c < 5000)
    begin
      @(posedge mclk);
      #1 c++;
    end
    if (c >= 5000)
    begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic pulse(input logic [15:0] v);
    @(negedge mclk);
    filt_valid = 1'b1;
    filt_data = v;
    @(negedge mclk);
    filt_valid = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    `CHK(data_ready_n, 1'b1)
    `CHK({conv_active, conv_start, result}, 18'h0)
    for (int i = 0; i < 8; i++)
    begin
      host.frame({8'h20, ROWS[i][30:23]}, 16, 0, rd);
      `CHK(mux_route & ROWS[i][14:7], ROWS[i][22:15] & ROWS[i][14:7])
      `CHK(gain_cfg, ROWS[i][6:0])
    end
    for (int c = 1; c < 7; c++)
    begin
      host.frame({8'h23, 3'(c), 3'(7 - c), 2'h0}, 16, 0, rd);
      `CHK(exc1.dest, 6'h01 << (c - 1))
      `CHK(exc2.dest, 6'h01 << (6 - c))
    end
    host.frame({8'h21, 8'hB0}, 16, 0, rd);
    `CHK({data_rate, turbo}, 4'hB)
    host.frame(16'h0011, 8, 8, rd);
    `CHK(rd[7:0], 8'hB0)
    // Single shot: one conversion, then idle with no further start.
    host.frame({8'h21, 8'h00}, 16, 0, rd);
    host.frame(16'h0002, 8, 0, rd);
    `CHK({conv_active, data_ready_n}, 2'b11)
    wait_start(n);
    `CHK(n > `ADCF_START_DELAY_CYC - 20 && n < `ADCF_START_DELAY_CYC + 10, 1'b1)
    pulse(16'hA5C3);
    `CHK({result, data_ready_n}, {16'hA5C3, 1'b0})
    @(negedge mclk);
    `CHK(conv_active, 1'b0)
    n = 0;
    repeat (4000)
    begin
      @(posedge mclk);
      #1 n += conv_start;
    end
    `CHK(n, 0)
    host.frame(16'h0004, 8, 16, rd);
    `CHK({rd, data_ready_n, sda_oe}, {16'hA5C3, 2'b10})
    // Continuous: each result starts the next conversion at once.
    host.frame({8'h21, 8'h08}, 16, 0, rd);
    host.frame(16'h0002, 8, 0, rd);
    wait_start(n);
    pulse(16'h1234);
    `CHK({conv_start, result}, {1'b1, 16'h1234})
    host.frame(16'h0004, 8, 16, rd);
    `CHK(rd, 16'h1234)
    pulse(16'h5678);
    `CHK({conv_start, conv_active, result}, {2'b11, 16'h5678})
    host.frame(16'h0003, 8, 0, rd);
    `CHK(conv_active, 1'b0)
    host.frame(16'h0001, 8, 0, rd);
    `CHK({data_rate, turbo, result}, {4'h0, 16'h5678})
    print_verdict();
  end
endmodule
